/* File: design/egress_oam_mip_extractor.v */
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "mip_defines.vh"
module egress_oam_mip_extractor (
	input  wire        ref_clk,
	input  wire        rst,
	// register port
	input  wire [9:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_we,
	input  wire        reg_re,
	output reg  [31:0] reg_rdata,
	// frame descriptor from the egress pipeline
	input  wire        frame_valid,
	output wire        frame_ready,
	input  wire [6:0]  intermediate_entry_index,
	input  wire [2:0]  frame_kind_tag,
	input  wire [7:0]  frame_opcode,
	input  wire [2:0]  frame_level,
	input  wire [47:0] frame_dest_addr,
	input  wire [1:0]  tags_in_frame,
	input  wire [1:0]  tags_popped,
	input  wire [1:0]  tags_pushed,
	input  wire        push_is_mpls,
	input  wire [1:0]  outer_tpid_index,
	input  wire [11:0] outer_vlan_id,
	input  wire [11:0] pushed_vlan_id,
	input  wire        software_endpoint_action,
	// central oam processor
	output reg         proc_req,
	output reg  [7:0]  proc_opcode,
	input  wire        proc_rsp_valid,
	input  wire        proc_rsp_active,
	input  wire        proc_rsp_consume,
	input  wire [15:0] proc_rsp_mod_cmd,
	input  wire        proc_rsp_stats,
	input  wire        proc_rsp_isdx_valid,
	input  wire [9:0]  proc_rsp_isdx,
	// pdu modifier and frame result
	output reg         pdu_modifier_valid,
	output reg  [15:0] pdu_modifier_cmd,
	output reg         pdu_modifier_stats,
	output reg         result_valid,
	output reg         result_cpu_copy,
	output reg         result_cpu_redirect,
	output reg         result_discard,
	output reg  [2:0]  cpu_extract_queue,
	output reg         service_index_valid,
	output reg  [9:0]  service_index,
	// port endpoint counter indexing
	output reg         endpoint_untagged,
	output reg  [2:0]  endpoint_priority,
	output reg         endpoint_drop_eligible
);
	// ------------------------------------------------------------
	// state and storage
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	reg [`CFG_W-1:0] cfg_q     [0:`ENTRIES-1];
	reg [1:0]        ivl_q     [0:`ENTRIES-1];
	reg [11:0]       vid_q     [0:`ENTRIES-1];
	reg [1:0]        vsel_q    [0:`ENTRIES-1];
	reg [15:0]       mac_hi_q  [0:`ENTRIES-1];
	reg [31:0]       mac_lo_q  [0:`ENTRIES-1];
	reg [`ENTRIES-1:0] once_q;
	reg [3:0]        arm_mask_q;
	reg              arm_busy_q;
	reg [6:0]        arm_idx_q;
	reg [6:0]        events_q;
	reg [3:0]        tpid_blind_q;
	reg [2:0]        def_pcp_q;
	reg              def_dei_q;
	reg [1:0]        state_q;
	// captured frame
	reg [6:0]  f_idx_q;
	reg [2:0]  f_kind_q;
	reg [7:0]  f_op_q;
	reg [2:0]  f_lvl_q;
	reg [47:0] f_da_q;
	reg        f_single_q;
	reg        f_untag_q;
	reg [11:0] f_vid_q;
	reg        f_swmep_q;
	wire [2:0] sel    = reg_addr[9:7];
	wire [6:0] widx   = reg_addr[6:0];
	wire       take   = frame_valid && (state_q == ST_IDLE);
	wire       finish = proc_rsp_valid && (state_q == ST_WAIT);
	assign frame_ready = (state_q == ST_IDLE);
	// ------------------------------------------------------------
	// tag classification at capture
	// ------------------------------------------------------------
	// tags left after pops; pops never exceed tags present
	wire [1:0] remain  = tags_in_frame - tags_popped;
	wire       tpid_ok = !tpid_blind_q[outer_tpid_index];
	// mpls pushes carry no usable vid and count as no vlan push
	wire [1:0] vpush   = push_is_mpls ? 2'h0 : tags_pushed;
	wire       no_push = (tags_pushed == 2'h0) && !push_is_mpls;
	wire       sgl_keep = (remain == 2'h1) && (vpush == 2'h0) && tpid_ok;
	wire       sgl_push = (remain == 2'h0) && (vpush == 2'h1);
	wire       single  = sgl_keep || sgl_push;
	wire       untag   = ((remain == 2'h0) && (vpush == 2'h0)) ||
		((remain == 2'h1) && no_push && !tpid_ok);
	wire       blind_outer = (tags_in_frame != 2'h0) && no_push &&
		tpid_blind_q[outer_tpid_index];

	// ------------------------------------------------------------
	// decision on the captured frame
	// ------------------------------------------------------------
	wire [`CFG_W-1:0] row = cfg_q[f_idx_q];
	wire [1:0]  vs     = vsel_q[f_idx_q];
	wire [47:0] ent_da = {mac_hi_q[f_idx_q], mac_lo_q[f_idx_q]};
	// kind tag is the only source of the Frame_kind_tag
	wire is_oam  = (f_kind_q == `KIND_Y1731);
	wire op_ccm  = f_op_q == `OP_CCM;
	wire op_lbm  = f_op_q == `OP_LBM;
	wire op_ltm  = f_op_q == `OP_LTM;
	wire op_raps = f_op_q == `OP_RAPS;
	wire op_gen  = f_op_q == row[`CFG_OPCODE];
	wire known   = op_ccm || op_lbm || op_ltm || op_raps || op_gen;
	wire active  = is_oam && (f_idx_q != 7'h00) && known;
	wire lvl_ok  = f_lvl_q == row[`CFG_LEVEL];
	reg vid_ok;
	// filter select decode; multi-tagged fails both tagged checks
	always @* begin
		case (vs)
		`VF_OFF:    vid_ok = 1'b1;
		`VF_UNTAG:  vid_ok = f_untag_q;
		`VF_SINGLE: vid_ok = f_single_q &&
			(f_vid_q == vid_q[f_idx_q]);
		`VF_BOTH:   vid_ok = f_untag_q || (f_single_q &&
			(f_vid_q == vid_q[f_idx_q]));
		default:    vid_ok = 1'b0;
		endcase
	end
	// entry acts only through filter and own level
	wire hit    = active && vid_ok && lvl_ok && !f_swmep_q;
	wire da_chk = ent_da != 48'h000000000000;
	wire da_ok  = !da_chk || (ent_da == f_da_q);
	wire ccm_en  = row[`CFG_CCM] || once_q[f_idx_q];
	wire ev_ccm  = hit && op_ccm && ccm_en;
	wire ev_once = hit && op_ccm && once_q[f_idx_q];
	wire ev_lbm  = hit && op_lbm && row[`CFG_LBM] && da_ok;
	wire ev_dafl = hit && op_lbm && row[`CFG_LBM] && !da_ok;
	wire ev_ltm  = hit && op_ltm && row[`CFG_LTM];
	wire ev_raps = hit && op_raps && (row[`CFG_RAPS] != `HANDLE_NONE);
	wire ev_gen  = hit && !op_raps && op_gen &&
		(row[`CFG_GENERIC] != `HANDLE_NONE);
	// level mismatch only counts for frames the entry would handle
	wire ev_mel  = active && vid_ok && !lvl_ok && !f_swmep_q;
	wire [1:0] h_raps = ev_raps ? row[`CFG_RAPS] : `HANDLE_NONE;
	wire [1:0] h_gen  = ev_gen ? row[`CFG_GENERIC] : `HANDLE_NONE;
	wire m_copy  = ev_ccm || h_raps == `HANDLE_COPY ||
		h_gen == `HANDLE_COPY;
	wire m_redir = ev_lbm || ev_ltm || h_raps == `HANDLE_REDIR ||
		h_gen == `HANDLE_REDIR;
	wire m_drop  = h_raps == `HANDLE_DROP || h_gen == `HANDLE_DROP;
	// rewriter inbound point acts ahead of the processor, outbound
	// point only when the processor has not consumed the frame
	wire proc_wins = proc_rsp_active && proc_rsp_consume &&
		row[`CFG_PIPE];
	wire mip_go    = !proc_wins;

	// ------------------------------------------------------------
	// frame sequencer: capture, ask processor, apply answer
	// ------------------------------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			proc_req <= 1'b0;
			proc_opcode <= 8'h00;
			f_idx_q <= 7'h00;
			f_kind_q <= 3'h0;
			f_op_q <= 8'h00;
			f_lvl_q <= 3'h0;
			f_da_q <= 48'h000000000000;
			f_single_q <= 1'b0;
			f_untag_q <= 1'b0;
			f_vid_q <= 12'h000;
			f_swmep_q <= 1'b0;
			pdu_modifier_valid <= 1'b0;
			pdu_modifier_cmd <= 16'h0000;
			pdu_modifier_stats <= 1'b0;
			result_valid <= 1'b0;
			result_cpu_copy <= 1'b0;
			result_cpu_redirect <= 1'b0;
			result_discard <= 1'b0;
			cpu_extract_queue <= 3'h0;
			service_index_valid <= 1'b0;
			service_index <= 10'h000;
			endpoint_untagged <= 1'b0;
			endpoint_priority <= 3'h0;
			endpoint_drop_eligible <= 1'b0;
		end else begin
			proc_req <= 1'b0;
			pdu_modifier_valid <= 1'b0;
			result_valid <= 1'b0;
			service_index_valid <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (take) begin
					f_idx_q <= intermediate_entry_index;
					f_kind_q <= frame_kind_tag;
					f_op_q <= frame_opcode;
					f_lvl_q <= frame_level;
					f_da_q <= frame_dest_addr;
					f_single_q <= single;
					f_untag_q <= untag;
					f_vid_q <= sgl_push ? pushed_vlan_id :
						outer_vlan_id;
					f_swmep_q <= software_endpoint_action;
					proc_req <= 1'b1;
					proc_opcode <= frame_opcode;
					// counters always see default priority and dei; untagged when no usable outer tag
					endpoint_untagged <= untag || blind_outer;
					endpoint_priority <= def_pcp_q;
					endpoint_drop_eligible <= def_dei_q;
					state_q <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (proc_rsp_valid) begin
					pdu_modifier_valid <= 1'b1;
					pdu_modifier_cmd <= proc_rsp_mod_cmd;
					pdu_modifier_stats <= proc_rsp_stats;
					service_index_valid <=
						proc_rsp_isdx_valid;
					service_index <= proc_rsp_isdx;
					result_valid <= 1'b1;
					result_cpu_copy <= mip_go && m_copy &&
						!m_redir;
					result_cpu_redirect <= mip_go && m_redir;
					result_discard <= mip_go && m_drop;
					cpu_extract_queue <= row[`CFG_QUEUE];
					state_q <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// table writes, once flags and arm-all sweep
	// ------------------------------------------------------------
	wire wr_tab = reg_we && (sel != `SEL_GLOBAL) && (sel < 3'h5);
	wire arm_go = reg_we && (reg_addr == `ADDR_GLOBAL_CTRL) &&
		reg_wdata[0];
	wire used_once = finish && mip_go && ev_once;
	integer i;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < `ENTRIES; i = i + 1) begin
				cfg_q[i] <= 22'h000000;
				ivl_q[i] <= 2'h0;
				vid_q[i] <= 12'h000;
				vsel_q[i] <= `VF_OFF;
				mac_hi_q[i] <= 16'h0000;
				mac_lo_q[i] <= 32'h00000000;
			end
		end else if (wr_tab) begin
			case (sel)
			`SEL_CFG:    cfg_q[widx] <= reg_wdata[`CFG_W-1:0];
			`SEL_ONCE:   ivl_q[widx] <= reg_wdata[2:1];
			`SEL_VLAN: begin
				vid_q[widx] <= reg_wdata[11:0];
				vsel_q[widx] <= reg_wdata[13:12];
			end
			`SEL_MAC_HI: mac_hi_q[widx] <= reg_wdata[15:0];
			`SEL_MAC_LO: mac_lo_q[widx] <= reg_wdata;
			default: ;
			endcase
		end
	end
	// one flag per entry: software write, hit clear, sweep set;
	// the sweep set is checked first so an arm in the same cycle wins
	genvar g;
	generate
		for (g = 0; g < `ENTRIES; g = g + 1) begin : once_bits
			wire sw_wr = wr_tab && (sel == `SEL_ONCE) &&
				(widx == g);
			wire clr   = used_once && (f_idx_q == g);
			wire arm   = arm_busy_q && (arm_idx_q == g) &&
				arm_mask_q[ivl_q[g]];
			always @(posedge ref_clk or posedge rst) begin
				if (rst)
					once_q[g] <= 1'b0;
				else if (arm)
					once_q[g] <= 1'b1;
				else if (clr)
					once_q[g] <= 1'b0;
				else if (sw_wr)
					once_q[g] <= reg_wdata[0];
			end
		end
	endgenerate
	// sweep visits one entry per cycle; trigger reads set until done
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arm_busy_q <= 1'b0;
			arm_idx_q <= 7'h00;
			arm_mask_q <= 4'h0;
		end else begin
			if (reg_we && (reg_addr == `ADDR_GLOBAL_CTRL))
				arm_mask_q <= reg_wdata[7:4];
			if (arm_busy_q) begin
				arm_idx_q <= arm_idx_q + 7'h01;
				if (arm_idx_q == 7'h7F)
					arm_busy_q <= 1'b0;
			end else if (arm_go) begin
				arm_busy_q <= 1'b1;
				arm_idx_q <= 7'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// sticky events and port control
	// ------------------------------------------------------------
	wire [6:0] ev_set = {7{finish && mip_go}} &
		{ev_mel, ev_dafl, ev_gen, ev_raps, ev_ltm, ev_lbm, ev_ccm};
	wire [6:0] ev_clr = (reg_we && (reg_addr == `ADDR_EVENTS)) ?
		reg_wdata[6:0] : 7'h00;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			events_q <= 7'h00;
			tpid_blind_q <= 4'h0;
			def_pcp_q <= 3'h0;
			def_dei_q <= 1'b0;
		end else begin
			// a new event beats a clear in the same cycle
			events_q <= (events_q & ~ev_clr) | ev_set;
			if (reg_we && (reg_addr == `ADDR_PORT_CTRL)) begin
				tpid_blind_q <= reg_wdata[3:0];
				def_pcp_q <= reg_wdata[6:4];
				def_dei_q <= reg_wdata[7];
			end
		end
	end

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h00000000;
		case (sel)
		`SEL_CFG:    rd_d = {10'h000, cfg_q[widx]};
		`SEL_ONCE:   rd_d = {29'h00000000, ivl_q[widx],
			once_q[widx]};
		`SEL_VLAN:   rd_d = {18'h00000, vsel_q[widx], vid_q[widx]};
		`SEL_MAC_HI: rd_d = {16'h0000, mac_hi_q[widx]};
		`SEL_MAC_LO: rd_d = mac_lo_q[widx];
		`SEL_GLOBAL: begin
			if (reg_addr == `ADDR_GLOBAL_CTRL)
				rd_d = {24'h000000, arm_mask_q, 3'h0,
					arm_busy_q};
			else if (reg_addr == `ADDR_EVENTS)
				rd_d = {25'h0000000, events_q};
			else if (reg_addr == `ADDR_PORT_CTRL)
				rd_d = {24'h000000, def_dei_q, def_pcp_q,
					tpid_blind_q};
		end
		default: rd_d = 32'h00000000;
		endcase
	end
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_re ? rd_d : 32'h00000000;
	end
endmodule // egress_oam_mip_extractor

/* File: design/mip_defines.vh */
`ifndef MIP_DEFINES_VH
`define MIP_DEFINES_VH

// ----------------------------------------------------------------
// table geometry and register map (word addresses)
// ----------------------------------------------------------------
`define ENTRIES          128
`define ADDR_W           10
`define SEL_CFG          3'h0
`define SEL_ONCE         3'h1
`define SEL_VLAN         3'h2
`define SEL_MAC_HI       3'h3
`define SEL_MAC_LO       3'h4
`define SEL_GLOBAL       3'h5
`define ADDR_GLOBAL_CTRL 10'h280
`define ADDR_EVENTS      10'h281
`define ADDR_PORT_CTRL   10'h282

// ----------------------------------------------------------------
// intermediate_point_config fields
// ----------------------------------------------------------------
`define CFG_W        22
`define CFG_LEVEL    2:0
`define CFG_CCM      3
`define CFG_LBM      4
`define CFG_LTM      5
`define CFG_RAPS     7:6
`define CFG_OPCODE   15:8
`define CFG_GENERIC  17:16
`define CFG_QUEUE    20:18
`define CFG_PIPE     21

// handling codes for ring protection and extra opcode
`define HANDLE_NONE  2'h0
`define HANDLE_COPY  2'h1
`define HANDLE_REDIR 2'h2
`define HANDLE_DROP  2'h3

// vlan filter select codes
`define VF_OFF       2'h0
`define VF_UNTAG     2'h1
`define VF_SINGLE    2'h2
`define VF_BOTH      2'h3

// frame kind and opcodes
`define KIND_Y1731   3'h1
`define OP_CCM       8'h01
`define OP_LBM       8'h03
`define OP_LTM       8'h05
`define OP_RAPS      8'h28

// sticky event bit positions
`define EV_CCM       0
`define EV_LBM       1
`define EV_LTM       2
`define EV_RAPS      3
`define EV_GENERIC   4
`define EV_DA_FAIL   5
`define EV_MEL_FAIL  6

`endif

/* File: verification/mip_extractor_checker_sva.sv */
`timescale 1ns/1ps
module mip_extractor_checker (
	input wire        ref_clk,
	input wire        rst,
	input wire [9:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_we,
	input wire        frame_valid,
	input wire        frame_ready,
	input wire [6:0]  intermediate_entry_index,
	input wire [2:0]  frame_kind_tag,
	input wire [1:0]  tags_in_frame,
	input wire [1:0]  tags_pushed,
	input wire        proc_req,
	input wire        proc_rsp_valid,
	input wire [15:0] proc_rsp_mod_cmd,
	input wire        proc_rsp_isdx_valid,
	input wire        pdu_modifier_valid,
	input wire [15:0] pdu_modifier_cmd,
	input wire        result_valid,
	input wire        result_cpu_copy,
	input wire        result_cpu_redirect,
	input wire        result_discard,
	input wire        service_index_valid,
	input wire        endpoint_untagged,
	input wire [2:0]  endpoint_priority
);
	logic       take;
	logic       active_q;
	logic [2:0] pcp_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	assign take = frame_valid && frame_ready;

	// shadow of activation and default priority, seen from the ports
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			active_q <= 1'b0;
			pcp_q <= 3'h0;
		end else begin
			if (take)
				active_q <= (intermediate_entry_index != 7'h00)
					&& (frame_kind_tag == 3'h1);
			if (reg_we && reg_addr == 10'h282)
				pcp_q <= reg_wdata[6:4];
		end
	end

	take_to_request_a: assert property (take |=> proc_req)
		else $error("no processor request after a frame was taken");
	hold_while_wait_a: assert property (proc_req |-> !frame_ready)
		else $error("frame accepted while answer outstanding");
	answer_to_result_a: assert property (
		proc_rsp_valid |=> result_valid && pdu_modifier_valid)
		else $error("answer not followed by result");
	result_has_cause_a: assert property (
		result_valid |-> $past(proc_rsp_valid) ##1 !result_valid)
		else $error("result without answer or longer than a cycle");
	modifier_follows_a: assert property (
		pdu_modifier_valid |-> pdu_modifier_cmd == $past(proc_rsp_mod_cmd))
		else $error("modifier command differs from answer");
	index_follows_a: assert property (
		proc_rsp_valid && proc_rsp_isdx_valid |=> service_index_valid)
		else $error("service index not passed on");
	inactive_quiet_a: assert property (result_valid && !active_q
		|-> !(result_cpu_copy || result_cpu_redirect || result_discard))
		else $error("inactive entry acted on a frame");
	untagged_default_a: assert property (
		take && tags_in_frame == 2'h0 && tags_pushed == 2'h0
		|=> endpoint_untagged && endpoint_priority == pcp_q)
		else $error("untagged frame lacks default priority");
	ready_after_a: assert property (result_valid |-> frame_ready)
		else $error("not ready after result");

	cover property (result_valid && result_cpu_copy);
	cover property (result_valid && result_cpu_redirect);
	cover property (result_valid && result_discard);
endmodule // mip_extractor_checker

bind egress_oam_mip_extractor mip_extractor_checker u_mip_extractor_checker (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .frame_valid(frame_valid),
	.frame_ready(frame_ready),
	.intermediate_entry_index(intermediate_entry_index),
	.frame_kind_tag(frame_kind_tag), .tags_in_frame(tags_in_frame),
	.tags_pushed(tags_pushed), .proc_req(proc_req),
	.proc_rsp_valid(proc_rsp_valid), .proc_rsp_mod_cmd(proc_rsp_mod_cmd),
	.proc_rsp_isdx_valid(proc_rsp_isdx_valid),
	.pdu_modifier_valid(pdu_modifier_valid), .pdu_modifier_cmd(pdu_modifier_cmd),
	.result_valid(result_valid), .result_cpu_copy(result_cpu_copy),
	.result_cpu_redirect(result_cpu_redirect),
	.result_discard(result_discard),
	.service_index_valid(service_index_valid),
	.endpoint_untagged(endpoint_untagged),
	.endpoint_priority(endpoint_priority)
);

/* File: verification/oam_processor_model.sv */
`timescale 1ns/1ps
module oam_processor_model (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        proc_req,
	input  wire [3:0]  dly,
	input  wire        act,
	input  wire        cons,
	input  wire [15:0] cmd,
	output logic       proc_rsp_valid,
	output wire        proc_rsp_active,
	output wire        proc_rsp_consume,
	output wire [15:0] proc_rsp_mod_cmd,
	output wire        proc_rsp_stats,
	output wire        proc_rsp_isdx_valid,
	output wire [9:0]  proc_rsp_isdx
);
	logic [3:0] cnt;
	logic       busy;

	// one answer per request, dly+1 cycles after the request pulse (dly of 0 acts as 1)
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			proc_rsp_valid <= 1'b0;
		end else begin
			proc_rsp_valid <= 1'b0;
			if (proc_req) begin
				busy <= 1'b1;
				cnt <= dly;
			end else if (busy && cnt <= 4'h1) begin
				busy <= 1'b0;
				proc_rsp_valid <= 1'b1;
			end else begin
				cnt <= cnt - 4'h1;
			end
		end
	end

	// fields mean something only with the pulse; inverted otherwise so
	// a late sample never matches by luck
	assign proc_rsp_active = proc_rsp_valid ? act : ~act;
	assign proc_rsp_consume = proc_rsp_valid ? cons : ~cons;
	assign proc_rsp_mod_cmd = proc_rsp_valid ? cmd : ~cmd;
	assign proc_rsp_stats = proc_rsp_valid ? cmd[0] : ~cmd[0];
	assign proc_rsp_isdx_valid = proc_rsp_valid;
	assign proc_rsp_isdx = proc_rsp_valid ? 10'h2AB : 10'h154;
endmodule // oam_processor_model

/* File: verification/egress_oam_mip_extractor_tb_top.sv */
`timescale 1ns/1ps
module egress_oam_mip_extractor_tb_top;
	logic        ref_clk, rst, reg_we, reg_re, frame_valid, act, cons, swa;
	logic [9:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [20:0] fr;
	logic [8:0]  tg;
	logic [47:0] da;
	logic [15:0] cmd;
	logic [3:0]  dly;
	logic [11:0] ovid, pvid;
	wire  [31:0] reg_rdata;
	wire  [15:0] rcmd, pdu_modifier_cmd;
	wire  [9:0]  isdx, si;
	wire  [7:0]  proc_opcode;
	wire  [2:0]  queue, ep_p;
	wire         frame_ready, proc_req, rv, ra, rc, rs, riv, pmv, pms;
	wire         result_valid, copy, redir, disc, siv, ep_u, ep_d;
	int          n_mismatch, checked, cycles;

	egress_oam_mip_extractor u_egress_oam_mip_extractor (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .intermediate_entry_index(fr[20:14]),
		.frame_kind_tag(fr[13:11]), .frame_opcode(fr[10:3]),
		.frame_level(fr[2:0]), .frame_dest_addr(da),
		.tags_in_frame(tg[8:7]), .tags_popped(tg[6:5]),
		.tags_pushed(tg[4:3]), .push_is_mpls(tg[2]),
		.outer_tpid_index(tg[1:0]), .outer_vlan_id(ovid),
		.pushed_vlan_id(pvid), .software_endpoint_action(swa),
		.proc_req(proc_req), .proc_opcode(proc_opcode),
		.proc_rsp_valid(rv), .proc_rsp_active(ra), .proc_rsp_consume(rc),
		.proc_rsp_mod_cmd(rcmd), .proc_rsp_stats(rs),
		.proc_rsp_isdx_valid(riv), .proc_rsp_isdx(isdx),
		.pdu_modifier_valid(pmv), .pdu_modifier_cmd(pdu_modifier_cmd),
		.pdu_modifier_stats(pms), .result_valid(result_valid),
		.result_cpu_copy(copy), .result_cpu_redirect(redir),
		.result_discard(disc), .cpu_extract_queue(queue),
		.service_index_valid(siv), .service_index(si),
		.endpoint_untagged(ep_u), .endpoint_priority(ep_p),
		.endpoint_drop_eligible(ep_d)
	);

	oam_processor_model u_oam_processor_model (
		.ref_clk(ref_clk), .rst(rst), .proc_req(proc_req), .dly(dly),
		.act(act), .cons(cons), .cmd(cmd), .proc_rsp_valid(rv),
		.proc_rsp_active(ra), .proc_rsp_consume(rc),
		.proc_rsp_mod_cmd(rcmd), .proc_rsp_stats(rs),
		.proc_rsp_isdx_valid(riv), .proc_rsp_isdx(isdx)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// -------------------------------------------------------------
	// checking and closing
	// -------------------------------------------------------------
	task chk(input logic [47:0] s, input logic [47:0] e);
		begin
			checked++;
			if (s !== e) begin
				n_mismatch++;
				$display("Error at %0t: seen %h expected %h", $time, s, e);
			end
		end
	endtask

	task tally_and_finish;
		begin
			if (n_mismatch == 0 && checked > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	// hang guard: the whole sequence needs well under a tenth of this
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end

	// -------------------------------------------------------------
	// register port and frame tasks
	// -------------------------------------------------------------
	task wr(input [9:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_we <= 1'b1;
			@(posedge ref_clk);
			reg_we <= 1'b0;
		end
	endtask

	// read data stand only in the cycle after the strobe
	task rd(input [9:0] a, input [31:0] e);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_re <= 1'b1;
			@(posedge ref_clk);
			reg_re <= 1'b0;
			@(negedge ref_clk);
			chk(reg_rdata, e);
		end
	endtask

	// e = {copy, redirect, discard}; entry queue is always 6 here
	task offer(input [6:0] i, input [2:0] k, input [7:0] o,
		input [2:0] l, input [2:0] e);
		int n;
		begin
			@(posedge ref_clk);
			fr <= {i, k, o, l};
			frame_valid <= 1'b1;
			cmd <= cmd + 16'h0101;
			@(posedge ref_clk);
			frame_valid <= 1'b0;
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (result_valid !== 1'b1 && n < 40);
			chk(n < 40, 1'b1);
			chk({copy, redir, disc}, e);
			chk(pdu_modifier_cmd, cmd);
			chk(si, 10'h2AB);
			chk(proc_opcode, o);
			chk(pms, cmd[0]);
			if (e[2] | e[1])
				chk(queue, 3'h6);
			// return on a rising edge so callers drive right after it
			@(posedge ref_clk);
		end
	endtask

	// vlan filter of entry 5 with tag layout tv, then a CCM
	task vf(input [1:0] sel, input [8:0] tv, input [2:0] e);
		begin
			wr(10'h105, {18'h0, sel, 12'h123});
			tg <= tv;
			offer(7'h05, 3'h1, 8'h01, 3'h3, e);
		end
	endtask

	initial begin
		{rst, reg_we, reg_re, frame_valid, act, cons, swa} = 7'h40;
		{reg_addr, reg_wdata, fr, tg, da, cmd} = 0;
		{n_mismatch, checked, cycles} = 0;
		{ovid, pvid} = 24'h123321;
		dly = 4'h1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(10'h005, 32'h0);
		rd(10'h3FF, 32'h0);
		wr(10'h005, 32'h001B30BB);
		rd(10'h005, 32'h001B30BB);
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h4);
		offer(7'h05, 3'h1, 8'h03, 3'h3, 3'h2);
		offer(7'h05, 3'h1, 8'h05, 3'h3, 3'h2);
		offer(7'h05, 3'h1, 8'h28, 3'h3, 3'h2);
		offer(7'h05, 3'h1, 8'h30, 3'h3, 3'h1);
		// copy handling for ring protection and the extra opcode
		wr(10'h005, 32'h0019307B);
		offer(7'h05, 3'h1, 8'h28, 3'h3, 3'h4);
		offer(7'h05, 3'h1, 8'h30, 3'h3, 3'h4);
		offer(7'h05, 3'h1, 8'h01, 3'h2, 3'h0);
		offer(7'h00, 3'h1, 8'h01, 3'h3, 3'h0);
		offer(7'h05, 3'h2, 8'h01, 3'h3, 3'h0);
		rd(10'h281, 32'h5F);
		wr(10'h281, 32'h7F);
		rd(10'h281, 32'h0);
		wr(10'h185, 32'h0012);
		wr(10'h205, 32'h3456789A);
		da <= 48'h00123456789A;
		offer(7'h05, 3'h1, 8'h03, 3'h3, 3'h2);
		da <= 48'h0;
		offer(7'h05, 3'h1, 8'h03, 3'h3, 3'h0);
		rd(10'h281, 32'h22);
		wr(10'h282, 32'hD2);
		vf(2'h2, 9'h000, 3'h0);
		chk({ep_u, ep_p, ep_d}, 5'h1B);
		vf(2'h2, 9'h080, 3'h4);
		chk(ep_u, 1'b0);
		vf(2'h2, 9'h100, 3'h0);
		vf(2'h2, 9'h0A8, 3'h0);
		// pushed vid now matches, kept outer vid does not
		{ovid, pvid} <= 24'h124123;
		vf(2'h2, 9'h0A8, 3'h4);
		vf(2'h2, 9'h080, 3'h0);
		vf(2'h2, 9'h0AC, 3'h0);
		vf(2'h2, 9'h081, 3'h0);
		chk(ep_u, 1'b1);
		vf(2'h1, 9'h000, 3'h4);
		vf(2'h1, 9'h080, 3'h0);
		vf(2'h3, 9'h000, 3'h4);
		vf(2'h3, 9'h100, 3'h0);
		vf(2'h0, 9'h100, 3'h4);
		{act, cons, dly} <= 6'h36;
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h4);
		wr(10'h005, 32'h003B30BB);
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h0);
		{act, cons, swa} <= 3'h1;
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h0);
		swa <= 1'b0;
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h4);
		wr(10'h005, 32'h001B30B3);
		wr(10'h085, 32'h4);
		wr(10'h086, 32'h2);
		wr(10'h280, 32'h41);
		rd(10'h280, 32'h41);
		repeat (130) @(posedge ref_clk);
		rd(10'h280, 32'h40);
		rd(10'h085, 32'h5);
		rd(10'h086, 32'h2);
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h4);
		rd(10'h085, 32'h4);
		offer(7'h05, 3'h1, 8'h01, 3'h3, 3'h0);
		tally_and_finish;
	end
endmodule // egress_oam_mip_extractor_tb_top
